// [core/acc_pkg.sv]
package acc_pkg;

    // Register byte addresses (printed offsets are not all multiples of four)
    localparam logic [7:0] CTRL_IDX    = 8'h1F;
    localparam logic [7:0] RESULT_IDX  = 8'h1E;
    localparam logic [7:0] PORTCFG_IDX = 8'h9F;
    localparam logic [7:0] IRQCFG_IDX  = 8'h20;
    localparam logic [7:0] PORTRD_IDX  = 8'h21;
    localparam logic [9:0] CTRL_ADDR    = {CTRL_IDX, 2'b00};
    localparam logic [9:0] RESULT_ADDR  = {RESULT_IDX, 2'b00};
    localparam logic [9:0] PORTCFG_ADDR = {PORTCFG_IDX, 2'b00};
    localparam logic [9:0] IRQCFG_ADDR  = {IRQCFG_IDX, 2'b00};
    localparam logic [9:0] PORTRD_ADDR  = {PORTRD_IDX, 2'b00};

    // Control register fields
    localparam int CLKSEL_HI = 7;
    localparam int CLKSEL_LO = 6;
    localparam int CHSEL_HI  = 5;
    localparam int CHSEL_LO  = 3;
    localparam int GO_BIT    = 2;
    localparam int PWR_BIT   = 0;

    // Interrupt config register fields
    localparam int DONE_BIT  = 0;
    localparam int CIE_BIT   = 1;
    localparam int PIE_BIT   = 2;
    localparam int GIE_BIT   = 3;

    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [2:0] PORTCFG_RESET = 3'h0;

    localparam logic [1:0] CLK_DIV2  = 2'h0;
    localparam logic [1:0] CLK_DIV8  = 2'h1;
    localparam logic [1:0] CLK_DIV32 = 2'h2;
    localparam logic [1:0] CLK_RC    = 2'h3;

    localparam logic [5:0] DIV2_CYC  = 6'h02;
    localparam logic [5:0] DIV8_CYC  = 6'h08;
    localparam logic [5:0] DIV32_CYC = 6'h20;

    // Bit periods per conversion
    localparam logic [3:0] CONV_PERIODS = 4'h9;
    // Instruction cycle in oscillator periods before an RC conversion starts
    localparam logic [5:0] INSTR_CYC    = 6'h04;

    typedef enum logic [3:0] {
        ACC_IDLE  = 4'b0001,
        ACC_WAIT  = 4'b0010,
        ACC_CONV  = 4'b0100,
        ACC_DONE  = 4'b1000
    } acc_state_t;

endpackage

// [core/acc_tick.sv]
module acc_tick
    import acc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       run_i,
    input  wire logic [1:0] clk_sel_i,
    input  wire logic       rc_tick_i,
    output logic            tick_o
);
    import acc_pkg::*;

    logic [5:0] count;
    logic [5:0] limit;
    logic       rc_s1;
    logic       rc_s2;
    logic       rc_s3;

    always_comb begin
        case (clk_sel_i)
            CLK_DIV2:  limit = DIV2_CYC;
            CLK_DIV8:  limit = DIV8_CYC;
            default:   limit = DIV32_CYC;
        endcase
    end

    // RC clock edge enters through a synchroniser
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rc_s1 <= 1'b0;
            rc_s2 <= 1'b0;
            rc_s3 <= 1'b0;
        end else begin
            rc_s1 <= rc_tick_i;
            rc_s2 <= rc_s1;
            rc_s3 <= rc_s2;
        end
    end

    // Oscillator divider
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= 6'h00;
        end else if (!run_i || clk_sel_i == CLK_RC || count == limit - 6'h01) begin
            count <= 6'h00;
        end else begin
            count <= count + 6'h01;
        end
    end

    always_comb begin
        if (!run_i) begin
            tick_o = 1'b0;
        end else if (clk_sel_i == CLK_RC) begin
            tick_o = rc_s2 & ~rc_s3;
        end else begin
            tick_o = (count == limit - 6'h01);
        end
    end
endmodule

// [core/acc_portmap.sv]
module acc_portmap
    import acc_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1
)
(
    input  wire logic [2:0] cfg_i,
    output logic      [7:0] analog_o,
    output logic            vref_pin_o
);
    import acc_pkg::*;

    logic [7:0] map;
    // Bit order is channel order: 0,1,2,3,4(RA5),5,6,7
    always_comb begin
        vref_pin_o = 1'b0;
        case (cfg_i)
            3'h0: map = 8'hFF;
            3'h1: begin map = 8'hF7; vref_pin_o = 1'b1; end
            3'h2: map = 8'h1F;
            3'h3: begin map = 8'h17; vref_pin_o = 1'b1; end
            3'h4: map = 8'h0B;
            3'h5: begin map = 8'h03; vref_pin_o = 1'b1; end
            default: map = 8'h00;
        endcase
        analog_o = LARGE_PKG ? map : {3'h0, map[4:0]};
    end
endmodule

// [core/acc_top.sv]
module acc_top
    import acc_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        sleep_i,
    input  wire logic        rc_tick_i,
    input  wire logic [7:0]  pin_level_i,
    input  wire logic        cmp_high_i,
    output logic      [2:0]  sample_channel_o,
    output logic             sample_o,
    output logic      [7:0]  sar_trial_o,
    output logic             analog_powered_o,
    output logic      [7:0]  pin_analog_o,
    output logic             vref_pin_o,
    output logic             wake_o,
    output logic             irq_o
);
    import acc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Registers and state

    logic [1:0]  clk_sel;
    logic [2:0]  ch_sel;
    logic        go;
    logic        pwr_on;
    logic [2:0]  port_cfg;
    logic        done_flag;
    logic        cie;
    logic        pie;
    logic        global_irq_enable;
    logic [7:0]  result;
    logic [7:0]  sar;
    logic [3:0]  period_cnt;
    logic [5:0]  wait_cnt;
    logic        shut_off;
    logic        tick;
    logic        finish;
    logic        abort;
    logic        done_set;
    logic        wr_en;
    logic        rd_en;
    logic [9:0]  addr;
    logic [7:0]  pin_s1;
    logic [7:0]  pin_s2;
    logic [7:0]  analog_map;
    logic        sleep_s1;
    logic        sleep_s2;
    logic        cmp_s1;
    logic        cmp_s2;
    acc_state_t  state;
    acc_state_t  next_state;

    assign addr      = paddr_i[9:0];
    assign wr_en     = psel_i & penable_i & pwrite_i;
    assign rd_en     = psel_i & ~pwrite_i;
    assign pready_o  = 1'b1;
    assign pslverr_o = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1   <= 8'h00;
            pin_s2   <= 8'h00;
            sleep_s1 <= 1'b0;
            sleep_s2 <= 1'b0;
            cmp_s1   <= 1'b0;
            cmp_s2   <= 1'b0;
        end else begin
            pin_s1   <= pin_level_i;
            pin_s2   <= pin_s1;
            sleep_s1 <= sleep_i;
            sleep_s2 <= sleep_s1;
            cmp_s1   <= cmp_high_i;
            cmp_s2   <= cmp_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sub-blocks

    acc_tick u_tick (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (state == ACC_CONV),
        .clk_sel_i (clk_sel),
        .rc_tick_i (rc_tick_i),
        .tick_o    (tick)
    );

    acc_portmap #(
        .LARGE_PKG (LARGE_PKG)
    ) u_portmap (
        .cfg_i      (port_cfg),
        .analog_o   (analog_map),
        .vref_pin_o (vref_pin_o)
    );

    assign pin_analog_o = analog_map;

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer

    // Converter powered down in sleep with a non-RC clock
    assign shut_off = ~pwr_on | (sleep_s2 & clk_sel != CLK_RC) | (sleep_s2 & state == ACC_IDLE);
    assign abort    = (state == ACC_WAIT || state == ACC_CONV) &&
                      (!go || !pwr_on || (sleep_s2 && clk_sel != CLK_RC));
    assign finish   = (state == ACC_CONV) && tick && (period_cnt == CONV_PERIODS - 4'h1) && !abort;
    assign done_set = (state == ACC_DONE);

    always_comb begin
        next_state = state;
        case (state)
            ACC_IDLE: begin
                if (go && pwr_on) begin
                    next_state = (clk_sel == CLK_RC) ? ACC_WAIT : ACC_CONV;
                end
            end
            ACC_WAIT: begin
                if (abort) begin
                    next_state = ACC_IDLE;
                end else if (wait_cnt == INSTR_CYC - 6'h01) begin
                    next_state = ACC_CONV;
                end
            end
            ACC_CONV: begin
                if (abort) begin
                    next_state = ACC_IDLE;
                end else if (finish) begin
                    next_state = ACC_DONE;
                end
            end
            ACC_DONE:  next_state = ACC_IDLE;
            default:   next_state = ACC_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ACC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_cnt <= 6'h00;
        end else if (state == ACC_WAIT) begin
            wait_cnt <= wait_cnt + 6'h01;
        end else begin
            wait_cnt <= 6'h00;
        end
    end

    // Bit period counter and successive approximation
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            period_cnt <= 4'h0;
            sar        <= 8'h00;
        end else if (state != ACC_CONV) begin
            period_cnt <= 4'h0;
            sar        <= 8'h80;
        end else if (tick) begin
            period_cnt <= period_cnt + 4'h1;
            if (period_cnt != 4'h0) begin
                // Period 1..8 resolve bits 7..0; sample in period 0
                sar <= sar_step(sar, cmp_s2, period_cnt);
            end
        end
    end

    function automatic logic [7:0] sar_step(input logic [7:0] v, input logic hi, input logic [3:0] p);
        logic [2:0] b;
        logic [7:0] r;
        b = 3'(4'h8 - p);
        r = v;
        if (hi) begin
            r[b] = 1'b0;
        end
        if (b != 3'h0) begin
            r[b - 3'h1] = 1'b1;
        end
        return r;
    endfunction

    // Result only on completion; no reset value needed
    always_ff @(posedge clk_i) begin
        if (finish) begin
            result <= sar_step(sar, cmp_s2, 4'h8);
        end
    end

    assign sample_channel_o = ch_sel;
    assign sample_o         = (state == ACC_CONV) && (period_cnt == 4'h0);
    assign sar_trial_o      = sar;
    assign analog_powered_o = ~shut_off & ~(state == ACC_IDLE & sleep_s2);

    ////////////////////////////////////////////////////////////////////////
    // Control register

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_sel <= CTRL_RESET[CLKSEL_HI:CLKSEL_LO];
            ch_sel  <= CTRL_RESET[CHSEL_HI:CHSEL_LO];
            pwr_on  <= CTRL_RESET[PWR_BIT];
        end else if (wr_en && addr == CTRL_ADDR) begin
            clk_sel <= pwdata_i[CLKSEL_HI:CLKSEL_LO];
            ch_sel  <= pwdata_i[CHSEL_HI:CHSEL_LO];
            pwr_on  <= pwdata_i[PWR_BIT];
        end
    end

    // Go flag: set by software, cleared by completion or abort
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            go <= CTRL_RESET[GO_BIT];
        end else if (wr_en && addr == CTRL_ADDR) begin
            go <= pwdata_i[GO_BIT];
        end else if (finish || abort) begin
            go <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_cfg <= PORTCFG_RESET;
        end else if (wr_en && addr == PORTCFG_ADDR) begin
            port_cfg <= pwdata_i[2:0];
        end
    end

    // Done flag: hardware set wins over software clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_flag <= 1'b0;
            cie       <= 1'b0;
            pie       <= 1'b0;
            global_irq_enable       <= 1'b0;
        end else begin
            if (wr_en && addr == IRQCFG_ADDR) begin
                cie <= pwdata_i[CIE_BIT];
                pie <= pwdata_i[PIE_BIT];
                global_irq_enable <= pwdata_i[GIE_BIT];
            end
            if (done_set) begin
                done_flag <= 1'b1;
            end else if (wr_en && addr == IRQCFG_ADDR) begin
                done_flag <= pwdata_i[DONE_BIT];
            end
        end
    end

    assign wake_o = done_flag & cie & pie;
    assign irq_o  = done_flag & cie & pie & global_irq_enable;

    ////////////////////////////////////////////////////////////////////////
    // Read data

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (rd_en && !penable_i) begin
            case (addr)
                CTRL_ADDR:    prdata_o <= {24'h0, clk_sel, ch_sel, go, 1'b0, pwr_on};
                RESULT_ADDR:  prdata_o <= {24'h0, result};
                PORTCFG_ADDR: prdata_o <= {29'h0, port_cfg};
                IRQCFG_ADDR:  prdata_o <= {28'h0, global_irq_enable, pie, cie, done_flag};
                PORTRD_ADDR:  prdata_o <= {24'h0, pin_s2 & ~analog_map};
                default:      prdata_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// [dv/acc_top_assertions.sv]
module acc_top_checker
    import acc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic        sleep_i,
    input  wire logic [2:0]  sample_channel_o,
    input  wire logic        sample_o,
    input  wire logic        analog_powered_o,
    input  wire logic [7:0]  pin_analog_o,
    input  wire logic        wake_o,
    input  wire logic        irq_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       ctl_wr;
    logic [1:0] clk_sel;
    logic       gie_seen;

    assign ctl_wr = psel_i && penable_i && pwrite_i && (paddr_i[9:0] == CTRL_ADDR);

    // Last written clock select
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_sel <= CLK_DIV2;
        end else if (ctl_wr) begin
            clk_sel <= pwdata_i[CLKSEL_HI:CLKSEL_LO];
        end
    end

    // Last written global interrupt enable
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gie_seen <= 1'b0;
        end else if (psel_i && penable_i && pwrite_i && paddr_i[9:0] == IRQCFG_ADDR) begin
            gie_seen <= pwdata_i[GIE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_CHANNEL: assert property (ctl_wr |=> sample_channel_o == $past(pwdata_i[CHSEL_HI:CHSEL_LO]))
        else $error("channel select not routed");
    AST_POWER_OFF: assert property (ctl_wr && !pwdata_i[PWR_BIT] |=> !analog_powered_o)
        else $error("converter powered after power bit cleared");
    AST_IRQ_GATE: assert property (irq_o == (wake_o && gie_seen))
        else $error("interrupt without wake request");
    AST_BIT_PERIOD: assert property ($rose(sample_o) && clk_sel == CLK_DIV8 |-> sample_o [*8] ##1 !sample_o)
        else $error("divide by 8 bit period wrong");
    AST_RESET_PINS: assert property ($rose(rst_n_i) |-> pin_analog_o == 8'hFF && !analog_powered_o)
        else $error("reset state of pins or power wrong");
    AST_SLEEP_OFF: assert property (sleep_i && $past(sleep_i, 4) && clk_sel != CLK_RC |-> !analog_powered_o)
        else $error("converter still on in sleep");
    AST_RC_WAIT: assert property (ctl_wr && pwdata_i[GO_BIT] && pwdata_i[CLKSEL_HI:CLKSEL_LO] == CLK_RC
                                  |=> !sample_o [*4])
        else $error("rc conversion started early");
    AST_OSC_START: assert property (ctl_wr && pwdata_i[GO_BIT] && pwdata_i[PWR_BIT] && !sample_o
                                    && pwdata_i[CLKSEL_HI:CLKSEL_LO] != CLK_RC |-> ##[1:2] sample_o)
        else $error("go did not start conversion");
endmodule

// [dv/acc_analog_model.sv]
module acc_analog_model (
    input  wire logic       clk_i,
    input  wire logic [2:0] channel_i,
    input  wire logic       sample_i,
    input  wire logic [7:0] trial_i,
    output logic            cmp_high_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] held = 8'h00;

    // Hold capacitor follows the routed pin while sampling
    always_ff @(posedge clk_i) begin
        if (sample_i) begin
            held <= {channel_i, 5'h0B};
        end
    end

    // Input below trial clears the trial bit
    assign cmp_high_o = held < trial_i;
endmodule

// [dv/test_adc_conversion_control.sv]
module test_adc_conversion_control;
    import acc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i       = 1'b0;
    logic        rst_n_i     = 1'b0;
    logic        psel_i      = 1'b0;
    logic        penable_i   = 1'b0;
    logic        pwrite_i    = 1'b0;
    logic [11:0] paddr_i     = 12'h000;
    logic [31:0] pwdata_i    = 32'h0;
    logic        sleep_i     = 1'b0;
    logic        rc_tick_i   = 1'b0;
    logic [7:0]  pin_level_i = 8'hFF;
    logic        cmp_high_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [2:0]  sample_channel_o;
    logic        sample_o;
    logic [7:0]  sar_trial_o;
    logic        analog_powered_o;
    logic [7:0]  pin_analog_o;
    logic        vref_pin_o;
    logic        wake_o;
    logic        irq_o;
    logic [31:0] rd;
    int          n_fail      = 0;
    int          check_count = 0;

    acc_top #(.LARGE_PKG(1'b1)) i_acc_top (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .sleep_i, .rc_tick_i, .pin_level_i, .cmp_high_i, .sample_channel_o,
        .sample_o, .sar_trial_o, .analog_powered_o, .pin_analog_o, .vref_pin_o, .wake_o, .irq_o);
    acc_analog_model i_acc_analog_model (.clk_i, .channel_i(sample_channel_o), .sample_i(sample_o),
        .trial_i(sar_trial_o), .cmp_high_o(cmp_high_i));

    initial forever #12.5 clk_i = ~clk_i;
    initial forever #1000 rc_tick_i = ~rc_tick_i;

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= {2'b00, a};
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic chk_reg(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask

    function automatic logic [31:0] ctl(input logic [1:0] sel, input logic [2:0] ch, input logic go);
        return {24'h0, sel, ch, go, 1'b0, 1'b1};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(32'(pin_analog_o), 32'hFF);
        chk({30'h0, pready_o, pslverr_o}, 32'h2);
        chk_reg(CTRL_ADDR, 32'hFF, 32'h0);
        chk_reg(PORTCFG_ADDR, 32'hFF, 32'h0);
        chk_reg(IRQCFG_ADDR, 32'hF, 32'h0);
        chk_reg(10'h3F0, 32'hFFFFFFFF, 32'h0);
    endtask

    task automatic t_ports();
        logic [7:0] am [8] = '{8'hFF, 8'hF7, 8'h1F, 8'h17, 8'h0B, 8'h03, 8'h00, 8'h00};
        logic [7:0] vr;
        logic [7:0] mk;
        vr = 8'h2A;
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, PORTCFG_ADDR, 32'(c));
            mk = 8'hFF ^ {4'h0, vr[c], 3'h0};
            chk(32'(pin_analog_o & mk), 32'(am[c]));
            chk(32'(vref_pin_o), 32'(vr[c]));
            chk_reg(PORTCFG_ADDR, 32'hFF, 32'(c));
            chk_reg(PORTRD_ADDR, 32'(mk), 32'(~am[c] & mk));
        end
    endtask

    task automatic t_convert(input logic [1:0] sel, input logic [2:0] ch);
        int n;
        int len;
        len = int'(CONV_PERIODS) * int'(sel == CLK_DIV2 ? DIV2_CYC : sel == CLK_DIV8 ? DIV8_CYC : DIV32_CYC);
        apb(1'b1, CTRL_ADDR, ctl(sel, ch, 1'b0));
        repeat (20) @(posedge clk_i);
        apb(1'b1, IRQCFG_ADDR, 32'h0);
        apb(1'b1, CTRL_ADDR, ctl(sel, ch, 1'b1));
        n = 3;
        chk_reg(CTRL_ADDR, 32'h4, 32'h4);
        while (rd[GO_BIT] !== 1'b0) begin
            apb(1'b0, CTRL_ADDR, 32'h0);
            n += 3;
        end
        if (sel != CLK_RC) chk(32'(n >= len && n <= len + 8), 32'h1);
        if (sel != CLK_DIV2) chk_reg(RESULT_ADDR, 32'hFF, {24'h0, ch, 5'h0B});
        chk_reg(IRQCFG_ADDR, 32'h1, 32'h1);
    endtask

    task automatic t_irq();
        logic w;
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, IRQCFG_ADDR, {28'h0, 3'(k), 1'b1});
            w = k[0] & k[1];
            chk({30'h0, wake_o, irq_o}, {30'h0, w, w & k[2]});
        end
    endtask

    task automatic t_abort();
        apb(1'b1, CTRL_ADDR, ctl(CLK_DIV32, 3'h2, 1'b0));
        repeat (20) @(posedge clk_i);
        apb(1'b1, IRQCFG_ADDR, 32'h0);
        apb(1'b1, CTRL_ADDR, ctl(CLK_DIV32, 3'h2, 1'b1));
        repeat (100) @(posedge clk_i);
        apb(1'b1, CTRL_ADDR, ctl(CLK_DIV32, 3'h2, 1'b0));
        repeat (300) @(posedge clk_i);
        chk_reg(RESULT_ADDR, 32'hFF, 32'hEB);
        chk_reg(IRQCFG_ADDR, 32'h1, 32'h0);
    endtask

    task automatic t_sleep();
        int n;
        apb(1'b1, CTRL_ADDR, ctl(CLK_DIV32, 3'h4, 1'b0));
        repeat (20) @(posedge clk_i);
        apb(1'b1, CTRL_ADDR, ctl(CLK_DIV32, 3'h4, 1'b1));
        repeat (50) @(posedge clk_i);
        sleep_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk(32'(analog_powered_o), 32'h0);
        repeat (300) @(posedge clk_i);
        chk_reg(CTRL_ADDR, 32'h1, 32'h1);
        chk_reg(IRQCFG_ADDR, 32'h1, 32'h0);
        sleep_i <= 1'b0;
        apb(1'b1, IRQCFG_ADDR, 32'h6);
        apb(1'b1, CTRL_ADDR, ctl(CLK_RC, 3'h6, 1'b0));
        repeat (20) @(posedge clk_i);
        apb(1'b1, CTRL_ADDR, ctl(CLK_RC, 3'h6, 1'b1));
        sleep_i <= 1'b1;
        n = 0;
        while (wake_o !== 1'b1 && n < 3000) begin
            n++;
            @(posedge clk_i);
        end
        chk(32'(wake_o), 32'h1);
        chk(32'(analog_powered_o), 32'h0);
        chk_reg(CTRL_ADDR, 32'h4, 32'h0);
        chk_reg(RESULT_ADDR, 32'hFF, 32'hCB);
        sleep_i <= 1'b0;
        apb(1'b1, CTRL_ADDR, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_ports();
        apb(1'b1, PORTCFG_ADDR, 32'h6);
        for (int i = 0; i < 4; i++) t_convert(2'(i), 3'(2 * i + 1));
        t_irq();
        t_abort();
        t_sleep();
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        finish_test();
    end

    initial begin
        #500000;
        n_fail++;
        finish_test();
    end
endmodule

bind acc_top acc_top_checker i_acc_top_checker (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .sleep_i, .sample_channel_o, .sample_o, .analog_powered_o, .pin_analog_o, .wake_o, .irq_o);
